// ===== design/bstap_device.sv
// Purpose: device end of the boundary-scan test port
// Assumes: 40 MHz CLK oversamples the test clock (at least 100 ns period)
// Notes:   test clock edges are found by sampling, not used as a clock
//
// Functional notes
// - no boundary test while configuration runs
// - sample/preload captures pins, preloads output pattern
// - external test drives outputs, captures input pins
// - bypass is one-bit delay register
// - user signature shifts out on data out
// - identification code shifts out on data out
// - reconfiguration instruction loads configuration over port
// - instruction register is ten bits
// - signature: 7 user bits, 25 fixed
// - boundary chain length is per-variant constant
`timescale 1ns/100ps
`include "bstap_params.svh"

module bstap_device (
	// clock and reset
	input  wire logic                       CLK,
	input  wire logic                       RST,
	// test port
	bstap_if.dev                            TAP,
	// device pins and core
	input  wire logic [`BSTAP_BSR_LEN-1:0]  PIN_IN,
	input  wire logic [`BSTAP_BSR_LEN-1:0]  CORE_OUT,
	output logic [`BSTAP_BSR_LEN-1:0]       PIN_OUT,
	// signature and configuration
	input  wire logic [`BSTAP_USER_LEN-1:0] USER_BITS,
	input  wire logic                       CFG_BUSY,
	output logic [`BSTAP_CFG_LEN-1:0]       CFG_WORD,
	output logic                            CFG_STROBE,
	output bstap_pkg::bstap_ir_t            INSTR
);
	import bstap_pkg::*;

	// ------------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------------
	bstap_state_e               st_q, st_d;
	bstap_ir_t                  ir_q, ir_d, irs_q, irs_d;
	logic [`BSTAP_BSR_LEN-1:0]  bsr_q, bsr_d, upd_q, upd_d, pin_q, pin_d;
	// pin levels arrive unrelated to CLK: two flops before capture
	logic [`BSTAP_BSR_LEN-1:0]  pin_s1_q, pin_s2_q;
	logic [`BSTAP_SIG_LEN-1:0]  w32_q, w32_d;
	logic [`BSTAP_CFG_LEN-1:0]  cfs_q, cfs_d, cfw_q, cfw_d;
	logic [2:0]                 cfc_q, cfc_d;
	logic                       byp_q, byp_d, stb_q, stb_d;
	logic                       tdo_q, tdo_d, oe_q, oe_d;
	logic                       tck_s1_q, tck_s2_q, tck_s3_q;
	logic                       tms_s1_q, tms_s2_q, tdi_s1_q, tdi_s2_q;
	logic                       rise, fall, is_bsr, bsr_ok, sel_bit;

	assign rise       = tck_s2_q && !tck_s3_q;
	assign fall       = !tck_s2_q && tck_s3_q;
	assign is_bsr     = (ir_q == `BSTAP_INS_SAMPLE) || (ir_q == `BSTAP_INS_EXTEST);
	assign bsr_ok     = is_bsr && !CFG_BUSY;
	assign TAP.tdo    = tdo_q;
	assign TAP.tdo_oe = oe_q;
	assign PIN_OUT    = pin_q;
	assign CFG_WORD   = cfw_q;
	assign CFG_STROBE = stb_q;
	assign INSTR      = ir_q;

	// ------------------------------------------------------------------------
	// controller transitions
	// ------------------------------------------------------------------------
	function automatic bstap_state_e next_st(input bstap_state_e s, input logic m);
		case (s)
			BSTAP_TLR:    next_st = m ? BSTAP_TLR    : BSTAP_RTI;
			BSTAP_RTI:    next_st = m ? BSTAP_SEL_DR : BSTAP_RTI;
			BSTAP_SEL_DR: next_st = m ? BSTAP_SEL_IR : BSTAP_CAP_DR;
			BSTAP_CAP_DR: next_st = m ? BSTAP_EX1_DR : BSTAP_SH_DR;
			BSTAP_SH_DR:  next_st = m ? BSTAP_EX1_DR : BSTAP_SH_DR;
			BSTAP_EX1_DR: next_st = m ? BSTAP_UPD_DR : BSTAP_PAU_DR;
			BSTAP_PAU_DR: next_st = m ? BSTAP_EX2_DR : BSTAP_PAU_DR;
			BSTAP_EX2_DR: next_st = m ? BSTAP_UPD_DR : BSTAP_SH_DR;
			BSTAP_UPD_DR: next_st = m ? BSTAP_SEL_DR : BSTAP_RTI;
			BSTAP_SEL_IR: next_st = m ? BSTAP_TLR    : BSTAP_CAP_IR;
			BSTAP_CAP_IR: next_st = m ? BSTAP_EX1_IR : BSTAP_SH_IR;
			BSTAP_SH_IR:  next_st = m ? BSTAP_EX1_IR : BSTAP_SH_IR;
			BSTAP_EX1_IR: next_st = m ? BSTAP_UPD_IR : BSTAP_PAU_IR;
			BSTAP_PAU_IR: next_st = m ? BSTAP_EX2_IR : BSTAP_PAU_IR;
			BSTAP_EX2_IR: next_st = m ? BSTAP_UPD_IR : BSTAP_SH_IR;
			BSTAP_UPD_IR: next_st = m ? BSTAP_SEL_DR : BSTAP_RTI;
			default:      next_st = BSTAP_TLR;
		endcase
	endfunction : next_st

	// ------------------------------------------------------------------------
	// serial output select
	// ------------------------------------------------------------------------
	always_comb begin
		sel_bit = byp_q;
		if (st_q == BSTAP_SH_IR) begin
			sel_bit = irs_q[0];
		end else if (is_bsr) begin
			sel_bit = bsr_q[0];
		end else if (ir_q == `BSTAP_INS_IDCODE || ir_q == `BSTAP_INS_USERCODE) begin
			sel_bit = w32_q[0];
		end else if (ir_q == `BSTAP_INS_CFGLOAD) begin
			sel_bit = cfs_q[0];
		end
	end

	// ------------------------------------------------------------------------
	// next values
	// ------------------------------------------------------------------------
	always_comb begin
		st_d  = st_q;
		ir_d  = ir_q;
		irs_d = irs_q;
		bsr_d = bsr_q;
		upd_d = upd_q;
		w32_d = w32_q;
		cfs_d = cfs_q;
		cfw_d = cfw_q;
		cfc_d = cfc_q;
		byp_d = byp_q;
		stb_d = 1'b0;
		tdo_d = tdo_q;
		oe_d  = oe_q;
		// outputs follow the update stage only under external test
		pin_d = (ir_q == `BSTAP_INS_EXTEST && !CFG_BUSY) ? upd_q : CORE_OUT;
		if (rise) begin
			st_d = next_st(st_q, tms_s2_q);
			case (st_q)
				BSTAP_TLR: begin
					ir_d = `BSTAP_INS_IDCODE;
				end
				BSTAP_CAP_IR: begin
					irs_d = `BSTAP_IR_CAPTURE;
				end
				BSTAP_SH_IR: begin
					irs_d = {tdi_s2_q, irs_q[`BSTAP_IR_LEN-1:1]};
				end
				BSTAP_UPD_IR: begin
					ir_d = irs_q;
				end
				BSTAP_CAP_DR: begin
					byp_d = 1'b0;
					cfc_d = 3'h0;
					if (bsr_ok) begin
						bsr_d = pin_s2_q;
					end
					if (ir_q == `BSTAP_INS_IDCODE) begin
						w32_d = `BSTAP_IDCODE;
					end else if (ir_q == `BSTAP_INS_USERCODE) begin
						w32_d = {`BSTAP_SIG_FIXED, USER_BITS};
					end
				end
				BSTAP_SH_DR: begin
					byp_d = tdi_s2_q;
					w32_d = {tdi_s2_q, w32_q[`BSTAP_SIG_LEN-1:1]};
					if (is_bsr) begin
						bsr_d = {tdi_s2_q, bsr_q[`BSTAP_BSR_LEN-1:1]};
					end
					if (ir_q == `BSTAP_INS_CFGLOAD) begin
						cfs_d = {tdi_s2_q, cfs_q[`BSTAP_CFG_LEN-1:1]};
						cfc_d = cfc_q + 3'h1;
						if (cfc_q == `BSTAP_CFG_LAST) begin
							cfw_d = cfs_d;
							stb_d = 1'b1;
						end
					end
				end
				BSTAP_UPD_DR: begin
					if (bsr_ok) begin
						upd_d = bsr_q;
					end
				end
				default: ;
			endcase
		end
		if (fall) begin
			tdo_d = sel_bit;
			oe_d  = (st_q == BSTAP_SH_IR) || (st_q == BSTAP_SH_DR);
		end
	end

	// ------------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------------
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			st_q     <= BSTAP_TLR;
			ir_q     <= `BSTAP_INS_IDCODE;
			irs_q    <= '0;
			bsr_q    <= '0;
			upd_q    <= '0;
			pin_q    <= '0;
			w32_q    <= '0;
			cfs_q    <= '0;
			cfw_q    <= '0;
			cfc_q    <= 3'h0;
			byp_q    <= 1'b0;
			stb_q    <= 1'b0;
			tdo_q    <= 1'b0;
			oe_q     <= 1'b0;
			tck_s1_q <= 1'b0;
			tck_s2_q <= 1'b0;
			tck_s3_q <= 1'b0;
			tms_s1_q <= 1'b1;
			tms_s2_q <= 1'b1;
			tdi_s1_q <= 1'b0;
			tdi_s2_q <= 1'b0;
			pin_s1_q <= '0;
			pin_s2_q <= '0;
		end else begin
			st_q     <= st_d;
			ir_q     <= ir_d;
			irs_q    <= irs_d;
			bsr_q    <= bsr_d;
			upd_q    <= upd_d;
			pin_q    <= pin_d;
			w32_q    <= w32_d;
			cfs_q    <= cfs_d;
			cfw_q    <= cfw_d;
			cfc_q    <= cfc_d;
			byp_q    <= byp_d;
			stb_q    <= stb_d;
			tdo_q    <= tdo_d;
			oe_q     <= oe_d;
			tck_s1_q <= TAP.tck;
			tck_s2_q <= tck_s1_q;
			tck_s3_q <= tck_s2_q;
			tms_s1_q <= TAP.tms;
			tms_s2_q <= tms_s1_q;
			tdi_s1_q <= TAP.tdi;
			tdi_s2_q <= tdi_s1_q;
			pin_s1_q <= PIN_IN;
			pin_s2_q <= pin_s1_q;
		end
	end

endmodule : bstap_device

// ===== include/bstap_params.svh
// Purpose: constants shared by both ends of the boundary-scan test port
// Assumes: 40 MHz system clock on both ends
// Notes:   values marked arbitrary carry no meaning beyond simulation
`ifndef BSTAP_PARAMS_SVH
`define BSTAP_PARAMS_SVH

// ----------------------------------------------------------------------------
// register lengths
// ----------------------------------------------------------------------------
`define BSTAP_IR_LEN        10
`define BSTAP_SIG_LEN       32
`define BSTAP_USER_LEN      7
`define BSTAP_FIXED_LEN     25
`define BSTAP_CFG_LEN       8
`define BSTAP_BSR_LEN_V1    690
`define BSTAP_BSR_LEN_V2    798
`define BSTAP_BSR_LEN_V3    1050
`define BSTAP_BSR_LEN_V4    1308
`define BSTAP_BSR_LEN_V5    1446
`define BSTAP_BSR_LEN       `BSTAP_BSR_LEN_V1

// ----------------------------------------------------------------------------
// instruction codes
// ----------------------------------------------------------------------------
`define BSTAP_INS_EXTEST    10'h000
`define BSTAP_INS_SAMPLE    10'h005
`define BSTAP_INS_IDCODE    10'h006
`define BSTAP_INS_USERCODE  10'h007
`define BSTAP_INS_CFGLOAD   10'h002
`define BSTAP_INS_BYPASS    10'h3FF
`define BSTAP_IR_CAPTURE    10'h001

// ----------------------------------------------------------------------------
// fixed values (identity values arbitrary)
// ----------------------------------------------------------------------------
`define BSTAP_IDCODE        32'h00001001
`define BSTAP_SIG_FIXED     25'h0A5A5A5
`define BSTAP_CFG_LAST      3'h7

// ----------------------------------------------------------------------------
// host timing: test clock = system clock / 8 (200 ns)
// ----------------------------------------------------------------------------
`define BSTAP_DIV_SET       3'h0
`define BSTAP_DIV_SAMPLE    3'h7
`define BSTAP_RESET_TMS     12'h005
`define BSTAP_RESET_END     12'h006
`define BSTAP_PRE_IR        12'h004
`define BSTAP_PRE_DR        12'h003
`define BSTAP_LEN_W         11

`endif

// ===== include/bstap_pkg.sv
// Purpose: types shared by both ends of the boundary-scan test port
// Assumes: nothing
// Notes:   standard sixteen-state test controller
package bstap_pkg;

	// ------------------------------------------------------------------------
	// controller states
	// ------------------------------------------------------------------------
	typedef enum logic [3:0] {
		BSTAP_TLR, BSTAP_RTI,
		BSTAP_SEL_DR, BSTAP_CAP_DR, BSTAP_SH_DR, BSTAP_EX1_DR,
		BSTAP_PAU_DR, BSTAP_EX2_DR, BSTAP_UPD_DR,
		BSTAP_SEL_IR, BSTAP_CAP_IR, BSTAP_SH_IR, BSTAP_EX1_IR,
		BSTAP_PAU_IR, BSTAP_EX2_IR, BSTAP_UPD_IR
	} bstap_state_e;

	// ------------------------------------------------------------------------
	// host sequencer states
	// ------------------------------------------------------------------------
	typedef enum logic [1:0] {
		BSTAP_H_INIT, BSTAP_H_IDLE, BSTAP_H_SCAN
	} bstap_host_e;

	typedef logic [9:0] bstap_ir_t;

endpackage : bstap_pkg

// ===== include/bstap_if.sv
// Purpose: serial test port wires between controller and device
// Assumes: the device drives the data-out wire at all times; tdo_oe only goes to the checker
// Notes:   no clocking block
`timescale 1ns/100ps

interface bstap_if;
	logic tck;
	logic tms;
	logic tdi;
	logic tdo;
	logic tdo_oe;

	modport dev  (input tck, input tms, input tdi, output tdo, output tdo_oe);
	modport host (output tck, output tms, output tdi, input tdo, input tdo_oe);
endinterface : bstap_if

// ===== design/bstap_host.sv
// Purpose: test controller end: makes the test clock and runs scans
// Assumes: 40 MHz CLK; test clock is CLK divided by 8
// Notes:   config words pass a two-entry buffer before being scanned
`timescale 1ns/100ps
`include "bstap_params.svh"

module bstap_host (
	// clock and reset
	input  wire logic                     CLK,
	input  wire logic                     RST,
	// test port
	bstap_if.host                         TAP,
	// scan commands
	input  wire logic                     CMD_VALID,
	output logic                          CMD_READY,
	input  wire logic                     CMD_IR,
	input  wire logic [`BSTAP_LEN_W-1:0]  CMD_LEN,
	input  wire logic [`BSTAP_SIG_LEN-1:0] CMD_DATA,
	output logic                          RESP_VALID,
	output logic [`BSTAP_SIG_LEN-1:0]     RESP_DATA,
	// configuration stream
	input  wire logic                     CFG_MODE,
	input  wire logic                     CFG_IN_VALID,
	output logic                          CFG_IN_READY,
	input  wire logic [`BSTAP_CFG_LEN-1:0] CFG_IN_DATA
);
	import bstap_pkg::*;

	// ------------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------------
	bstap_host_e                st_q, st_d;
	logic [2:0]                 div_q, div_d;
	logic [11:0]                idx_q, idx_d;
	logic [11:0]                pre_q, pre_d;
	logic [11:0]                len_q, len_d;
	logic [`BSTAP_SIG_LEN-1:0]  dat_q, dat_d;
	logic [`BSTAP_SIG_LEN-1:0]  rsp_q, rsp_d;
	logic                       tms_q, tms_d, tdi_q, tdi_d, sh_q, sh_d, rv_q, rv_d;
	logic                       tdo_s1_q, tdo_s2_q;
	logic [`BSTAP_CFG_LEN-1:0]  buf_q [2];
	logic [`BSTAP_CFG_LEN-1:0]  buf_d [2];
	logic                       wp_q, wp_d, rp_q, rp_d;
	logic [1:0]                 cnt_q, cnt_d;
	logic                       push, pop, set_tick;
	logic [11:0]                last_sh;

	assign TAP.tck      = div_q[2];
	assign TAP.tms      = tms_q;
	assign TAP.tdi      = tdi_q;
	assign RESP_VALID   = rv_q;
	assign RESP_DATA    = rsp_q;
	assign CFG_IN_READY = (cnt_q != 2'h2);
	assign set_tick     = (div_q == `BSTAP_DIV_SET);
	assign CMD_READY    = (st_q == BSTAP_H_IDLE) && set_tick && !CFG_MODE;
	assign push         = CFG_IN_VALID && CFG_IN_READY;
	assign pop          = (st_q == BSTAP_H_IDLE) && set_tick && CFG_MODE && (cnt_q != 2'h0);
	assign last_sh      = pre_q + len_q - 12'h001;

	// ------------------------------------------------------------------------
	// next values
	// ------------------------------------------------------------------------
	always_comb begin
		st_d  = st_q;
		div_d = div_q + 3'h1;
		idx_d = idx_q;
		pre_d = pre_q;
		len_d = len_q;
		dat_d = dat_q;
		rsp_d = rsp_q;
		tms_d = tms_q;
		tdi_d = tdi_q;
		sh_d  = sh_q;
		rv_d  = 1'b0;
		buf_d = buf_q;
		wp_d  = wp_q;
		rp_d  = rp_q;
		cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
		if (push) begin
			buf_d[wp_q] = CFG_IN_DATA;
			wp_d        = ~wp_q;
		end
		if (pop) begin
			rp_d = ~rp_q;
		end
		if (div_q == `BSTAP_DIV_SAMPLE && sh_q) begin
			rsp_d = {tdo_s2_q, rsp_q[`BSTAP_SIG_LEN-1:1]};
		end
		if (set_tick) begin
			case (st_q)
				BSTAP_H_INIT: begin
					tms_d = (idx_q < `BSTAP_RESET_TMS);
					idx_d = idx_q + 12'h001;
					if (idx_q == `BSTAP_RESET_END) begin
						st_d  = BSTAP_H_IDLE;
						tms_d = 1'b0;
					end
				end
				BSTAP_H_IDLE: begin
					tms_d = 1'b0;
					sh_d  = 1'b0;
					idx_d = 12'h000;
					if (pop) begin
						st_d  = BSTAP_H_SCAN;
						pre_d = `BSTAP_PRE_DR;
						len_d = 12'(`BSTAP_CFG_LEN);
						dat_d = {{(`BSTAP_SIG_LEN-`BSTAP_CFG_LEN){1'b0}}, buf_q[rp_q]};
					end else if (CMD_READY && CMD_VALID) begin
						st_d  = BSTAP_H_SCAN;
						pre_d = CMD_IR ? `BSTAP_PRE_IR : `BSTAP_PRE_DR;
						len_d = CMD_IR ? 12'(`BSTAP_IR_LEN) : {1'b0, CMD_LEN};
						if (!CMD_IR && CMD_LEN == '0) begin
							len_d = 12'h001;
						end
						dat_d = CMD_DATA;
					end
				end
				BSTAP_H_SCAN: begin
					idx_d = idx_q + 12'h001;
					sh_d  = (idx_q >= pre_q) && (idx_q <= last_sh);
					tdi_d = 1'b0;
					if (idx_q == 12'h000) begin
						tms_d = 1'b1;
					end else if (idx_q == 12'h001) begin
						tms_d = (pre_q == `BSTAP_PRE_IR);
					end else if (idx_q < pre_q) begin
						tms_d = 1'b0;
					end else if (idx_q <= last_sh) begin
						tms_d = (idx_q == last_sh);
						tdi_d = dat_q[0];
						dat_d = {1'b0, dat_q[`BSTAP_SIG_LEN-1:1]};
					end else if (idx_q == last_sh + 12'h001) begin
						tms_d = 1'b1;
					end else begin
						tms_d = 1'b0;
						st_d  = BSTAP_H_IDLE;
						rv_d  = 1'b1;
					end
				end
				default: st_d = BSTAP_H_INIT;
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------------
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			st_q     <= BSTAP_H_INIT;
			div_q    <= 3'h0;
			idx_q    <= 12'h000;
			pre_q    <= 12'h000;
			len_q    <= 12'h000;
			dat_q    <= '0;
			rsp_q    <= '0;
			tms_q    <= 1'b1;
			tdi_q    <= 1'b0;
			sh_q     <= 1'b0;
			rv_q     <= 1'b0;
			buf_q    <= '{default: '0};
			wp_q     <= 1'b0;
			rp_q     <= 1'b0;
			cnt_q    <= 2'h0;
			tdo_s1_q <= 1'b0;
			tdo_s2_q <= 1'b0;
		end else begin
			st_q     <= st_d;
			div_q    <= div_d;
			idx_q    <= idx_d;
			pre_q    <= pre_d;
			len_q    <= len_d;
			dat_q    <= dat_d;
			rsp_q    <= rsp_d;
			tms_q    <= tms_d;
			tdi_q    <= tdi_d;
			sh_q     <= sh_d;
			rv_q     <= rv_d;
			buf_q    <= buf_d;
			wp_q     <= wp_d;
			rp_q     <= rp_d;
			cnt_q    <= cnt_d;
			tdo_s1_q <= TAP.tdo;
			tdo_s2_q <= tdo_s1_q;
		end
	end

endmodule : bstap_host

// ===== verif/bstap_checker.sv
// Purpose: watches the serial test port wires between the two ends
// Assumes: CLK oversamples tck; a controller model follows tck rises
// Notes:   scan lengths are judged against the last instruction updated
`timescale 1ns/100ps
`include "bstap_params.svh"

module bstap_checker
	import bstap_pkg::*;
(
	// clock and reset
	input wire logic CLK,
	input wire logic RST,
	// test port
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic tdo,
	input wire logic tdo_oe
);
	// ----
	// controller model
	// ----
	bstap_state_e st_q, st_d;
	bstap_ir_t    ir_q, ir_d, ins_q, ins_d;
	logic [10:0]  cnt_q, cnt_d;
	logic         tck_q, rise, sh;

	assign rise = tck & ~tck_q;
	assign sh   = (st_q == BSTAP_SH_DR) || (st_q == BSTAP_SH_IR);

	always_comb begin
		st_d  = st_q;
		ir_d  = ir_q;
		ins_d = ins_q;
		cnt_d = cnt_q;
		if (rise) begin
			case (st_q)
				BSTAP_TLR:                 st_d = tms ? BSTAP_TLR : BSTAP_RTI;
				BSTAP_RTI:                 st_d = tms ? BSTAP_SEL_DR : BSTAP_RTI;
				BSTAP_SEL_DR:              st_d = tms ? BSTAP_SEL_IR : BSTAP_CAP_DR;
				BSTAP_CAP_DR, BSTAP_SH_DR: st_d = tms ? BSTAP_EX1_DR : BSTAP_SH_DR;
				BSTAP_EX1_DR:              st_d = tms ? BSTAP_UPD_DR : BSTAP_PAU_DR;
				BSTAP_PAU_DR:              st_d = tms ? BSTAP_EX2_DR : BSTAP_PAU_DR;
				BSTAP_EX2_DR:              st_d = tms ? BSTAP_UPD_DR : BSTAP_SH_DR;
				BSTAP_SEL_IR:              st_d = tms ? BSTAP_TLR : BSTAP_CAP_IR;
				BSTAP_CAP_IR, BSTAP_SH_IR: st_d = tms ? BSTAP_EX1_IR : BSTAP_SH_IR;
				BSTAP_EX1_IR:              st_d = tms ? BSTAP_UPD_IR : BSTAP_PAU_IR;
				BSTAP_PAU_IR:              st_d = tms ? BSTAP_EX2_IR : BSTAP_PAU_IR;
				BSTAP_EX2_IR:              st_d = tms ? BSTAP_UPD_IR : BSTAP_SH_IR;
				default:                   st_d = tms ? BSTAP_SEL_DR : BSTAP_RTI;
			endcase
			if (st_q == BSTAP_CAP_DR || st_q == BSTAP_CAP_IR) cnt_d = 11'h000;
			if (sh) cnt_d = cnt_q + 11'h001;
			if (st_q == BSTAP_SH_IR) ir_d = {tdi, ir_q[9:1]};
			if (st_q == BSTAP_UPD_IR) ins_d = ir_q;
			if (st_q == BSTAP_TLR) ins_d = `BSTAP_INS_IDCODE;
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			st_q  <= BSTAP_TLR;
			ir_q  <= 10'h000;
			ins_q <= `BSTAP_INS_IDCODE;
			cnt_q <= 11'h000;
			tck_q <= 1'b0;
		end else begin
			st_q  <= st_d;
			ir_q  <= ir_d;
			ins_q <= ins_d;
			cnt_q <= cnt_d;
			tck_q <= tck;
		end
	end

	// ----
	// assertions
	// ----
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);

	a_tck_high_four: assert property (rise |-> tck [*4] ##1 !tck)
		else $error("test clock high time wrong");
	a_tms_low_edge: assert property ($changed(tms) |-> !tck)
		else $error("mode select moved while clock high");
	a_tdi_low_edge: assert property ($changed(tdi) |-> !tck)
		else $error("data in moved while clock high");
	a_tdo_hold_high: assert property (rise |-> ##2 $stable(tdo) [*3])
		else $error("data out moved while clock high");
	a_oe_in_shift: assert property (rise |-> ##2 (tdo_oe == $past(sh, 2)))
		else $error("data out enable outside shift");
	a_tdi_idle_zero: assert property (rise && !sh |-> !tdi)
		else $error("data in not low outside shift");
	a_ir_ten_bits: assert property (rise && st_q == BSTAP_SH_IR && tms |-> cnt_q == 11'h009)
		else $error("instruction scan length wrong");
	a_bsr_chain_len: assert property (rise && st_q == BSTAP_SH_DR && tms
		&& (ins_q == `BSTAP_INS_EXTEST || ins_q == `BSTAP_INS_SAMPLE) |-> cnt_q == `BSTAP_BSR_LEN - 1)
		else $error("boundary scan length wrong");
	a_sig_code_len: assert property (rise && st_q == BSTAP_SH_DR && tms
		&& (ins_q == `BSTAP_INS_IDCODE || ins_q == `BSTAP_INS_USERCODE) |-> cnt_q == 11'h01F)
		else $error("code scan length wrong");
	a_cfg_word_len: assert property (rise && st_q == BSTAP_SH_DR && tms
		&& ins_q == `BSTAP_INS_CFGLOAD |-> cnt_q == 11'h007)
		else $error("config word scan length wrong");

	c_ir_update: cover property (rise && st_q == BSTAP_UPD_IR);
	c_bsr_scan: cover property (rise && st_q == BSTAP_SH_DR && tms && cnt_q == 11'h2B1);
	c_oe_on: cover property ($rose(tdo_oe));

endmodule : bstap_checker

// ===== verif/boundary_scan_tap_tb.sv
// Purpose: drives the user sides of both ends and checks the results
// Assumes: host makes tck at CLK/8; boundary chain of 690 cells
// Notes:   expected responses are queued by the driver, compared on arrival
`timescale 1ns/100ps
`include "bstap_params.svh"

module boundary_scan_tap_tb;
	import bstap_pkg::*;

	localparam int N = `BSTAP_BSR_LEN;

	logic            clk, rst, cmd_valid, cmd_ready, cmd_ir, resp_valid;
	logic [10:0]     cmd_len;
	logic [31:0]     cmd_data, resp_data, seed, d, exp_q[$], msk_q[$];
	logic            cfg_mode, cfg_valid, cfg_ready, cfg_busy, cfg_strobe;
	logic [7:0]      cfg_data, cfg_word, cfg_q[$];
	logic [N-1:0]    pin_in, core_out, pin_out, v;
	logic [6:0]      user_bits;
	bstap_ir_t       instr;
	bstap_ir_t       byp[2] = '{`BSTAP_INS_BYPASS, 10'h155};
	int              num_errors, tests_run;

	bstap_if bstap_if_inst ();
	bstap_host bstap_host_inst (.CLK(clk), .RST(rst), .TAP(bstap_if_inst), .CMD_VALID(cmd_valid),
		.CMD_READY(cmd_ready), .CMD_IR(cmd_ir), .CMD_LEN(cmd_len), .CMD_DATA(cmd_data),
		.RESP_VALID(resp_valid), .RESP_DATA(resp_data), .CFG_MODE(cfg_mode),
		.CFG_IN_VALID(cfg_valid), .CFG_IN_READY(cfg_ready), .CFG_IN_DATA(cfg_data));
	bstap_device bstap_device_inst (.CLK(clk), .RST(rst), .TAP(bstap_if_inst), .PIN_IN(pin_in),
		.CORE_OUT(core_out), .PIN_OUT(pin_out), .USER_BITS(user_bits), .CFG_BUSY(cfg_busy),
		.CFG_WORD(cfg_word), .CFG_STROBE(cfg_strobe), .INSTR(instr));
	bstap_checker bstap_checker_inst (.CLK(clk), .RST(rst), .tck(bstap_if_inst.tck),
		.tms(bstap_if_inst.tms), .tdi(bstap_if_inst.tdi), .tdo(bstap_if_inst.tdo),
		.tdo_oe(bstap_if_inst.tdo_oe));

	// ----
	// helpers
	// ----
	function automatic logic [31:0] rnd();
		for (int i = 0; i < 32; i++) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction : rnd

	task automatic wide(output logic [N-1:0] w);
		logic [31:0] r;
		for (int i = 0; i < N; i++) begin
			if (i % 32 == 0) r = rnd();
			w[i] = r[i % 32];
		end
	endtask : wide

	task automatic check(input logic [N-1:0] seen, input logic [N-1:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wait_hi(ref logic s);
		int i = 0;
		do @(negedge clk); while (s !== 1'b1 && ++i < 9000);
	endtask : wait_hi

	task automatic scan(input logic ir, input logic [10:0] len, input logic [31:0] dat, e, m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_ir    <= ir;
		cmd_len   <= len;
		cmd_data  <= dat;
		wait_hi(cmd_ready);
		@(posedge clk);
		cmd_valid <= 1'b0;
		wait_hi(resp_valid);
		repeat (8) @(negedge clk);
	endtask : scan

	task automatic ir(input bstap_ir_t code);
		scan(1'b1, 11'h00A, {22'h0, code}, 32'h0040_0000, 32'hFFC0_0000);
		check(instr, code);
	endtask : ir

	task automatic cfg_push(input logic [7:0] w);
		@(posedge clk);
		cfg_valid <= 1'b1;
		cfg_data  <= w;
		cfg_q.push_back(w);
		wait_hi(cfg_ready);
		@(posedge clk);
		cfg_valid <= 1'b0;
	endtask : cfg_push

	task automatic results();
		if (num_errors == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : results

	// ----
	// clock, monitor, watchdog
	// ----
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	always @(negedge clk) begin
		if (resp_valid === 1'b1 && exp_q.size() > 0 && !cfg_mode)
			check(resp_data & msk_q.pop_front(), exp_q.pop_front());
		if (cfg_strobe === 1'b1 && cfg_q.size() > 0 && cfg_mode)
			check(cfg_word, cfg_q.pop_front());
		if (cfg_mode === 1'b1)
			check(cmd_ready, 1'b0);
	end

	initial begin
		repeat (60000) @(posedge clk);
		num_errors++;
		results();
	end

	// ----
	// scenarios
	// ----
	initial begin
		seed = 32'h2A59;
		num_errors = 0;
		tests_run = 0;
		{rst, cmd_valid, cmd_ir, cfg_mode, cfg_valid, cfg_busy} = 6'h20;
		{cmd_len, cmd_data, cfg_data} = '0;
		wide(pin_in);
		wide(core_out);
		d = rnd();
		user_bits = d[6:0];
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		check(instr, `BSTAP_INS_IDCODE);
		scan(1'b0, 11'h020, rnd(), `BSTAP_IDCODE, 32'hFFFF_FFFF);
		foreach (byp[k]) begin
			ir(byp[k]);
			wide(v);
			@(posedge clk);
			core_out <= v;
			d = rnd();
			scan(1'b0, 11'h008, d, {d[6:0], 25'h0}, 32'hFF00_0000);
			check(pin_out, v);
		end
		d = rnd();
		@(posedge clk);
		user_bits <= d[6:0];
		ir(`BSTAP_INS_USERCODE);
		scan(1'b0, 11'h020, rnd(), {`BSTAP_SIG_FIXED, d[6:0]}, 32'hFFFF_FFFF);
		ir(`BSTAP_INS_SAMPLE);
		d = rnd();
		scan(1'b0, 11'(N), d, pin_in[N-1 -: 32], 32'hFFFF_FFFF);
		check(pin_out, core_out);
		ir(`BSTAP_INS_EXTEST);
		check(pin_out, N'(d));
		wide(v);
		@(posedge clk);
		pin_in <= v;
		d = rnd();
		scan(1'b0, 11'(N), d, v[N-1 -: 32], 32'hFFFF_FFFF);
		check(pin_out, N'(d));
		@(posedge clk);
		cfg_busy <= 1'b1;
		repeat (3) @(negedge clk);
		check(pin_out, core_out);
		@(posedge clk);
		cfg_busy <= 1'b0;
		repeat (3) @(negedge clk);
		check(pin_out, N'(d));
		ir(`BSTAP_INS_CFGLOAD);
		d = rnd();
		cfg_push(d[7:0]);
		cfg_push(d[15:8]);
		@(negedge clk);
		check(cfg_ready, 1'b0);
		@(posedge clk);
		cfg_mode <= 1'b1;
		for (int i = 0; i < 3000 && cfg_q.size() > 0; i++) @(negedge clk);
		check(cfg_q.size(), 0);
		check(cfg_ready, 1'b1);
		@(posedge clk);
		cfg_mode <= 1'b0;
		results();
	end

endmodule : boundary_scan_tap_tb
